// *** rtl/ecb_defs.svh ***
/*
 * Constants of the A/B encoder counter: channel map, filter delays, mode codes.
 * Assumes a 25 MHz system clock and twelve digital input pins.
 */
`ifndef ECB_DEFS_SVH
`define ECB_DEFS_SVH

`define ECB_NUM_IN 12
`define ECB_NUM_ENC 2
`define ECB_CNT_W 32
`define ECB_FCNT_W 18

// Input channel of track A of encoder 0; track B is the next one
`define ECB_ENC_A_BASE 4
`define ECB_ENC_STRIDE 2
// Touch/reset inputs of encoder 0 start here, two per encoder
`define ECB_TOUCH_BASE 0

`define ECB_CLK_HZ 25000000
`define ECB_CYC_PER_US (`ECB_CLK_HZ / 1000000)
`define ECB_DLY_8MS_US 8000
`define ECB_DLY_1MS_US 1000
`define ECB_DLY_100US_US 100
`define ECB_DLY_100US_CYC (`ECB_DLY_100US_US * `ECB_CYC_PER_US)
`define ECB_DLY_MIN_CYC 1

`define ECB_MODE_QUAD 1'h0
`define ECB_MODE_PDIR 1'h1

`endif

// *** rtl/ecb_encoder_count_block.sv ***
/*
 * Two-channel A/B encoder counter with input filters, touch/reset preset and capture.
 * Assumes raw pins arrive asynchronously and control ports come from logic on clock.
 */
`timescale 1ns/1ps

module ecb_encoder_count_block
    import ecb_pkg::*;
#(
    parameter int FILT_8MS_CYC = `ECB_DLY_8MS_US * `ECB_CYC_PER_US,
    parameter int FILT_1MS_CYC = `ECB_DLY_1MS_US * `ECB_CYC_PER_US
)
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [`ECB_NUM_IN-1:0] din_pin,
    input wire logic [`ECB_NUM_IN-1:0][1:0] delay_sel,
    input wire logic [`ECB_NUM_ENC-1:0] enc_cfg,
    input wire logic [2*`ECB_NUM_ENC-1:0] touch_cfg,
    input wire logic [`ECB_NUM_ENC-1:0] count_enable,
    input wire logic [`ECB_NUM_ENC-1:0] count_mode,
    input wire logic [`ECB_NUM_ENC-1:0] count_set,
    input wire logic [`ECB_NUM_ENC-1:0][`ECB_CNT_W-1:0] count_preset,
    input wire logic [`ECB_NUM_ENC-1:0] wrap_limit_on,
    input wire logic [`ECB_NUM_ENC-1:0][`ECB_CNT_W-1:0] wrap_ceiling,
    input wire logic [`ECB_NUM_ENC-1:0] preset_arm,
    input wire logic [`ECB_NUM_ENC-1:0] capture_arm,
    output logic [`ECB_NUM_IN-1:0] din_filtered,
    output logic [`ECB_NUM_IN-1:0] plain_input,
    output logic [`ECB_NUM_ENC-1:0] enc_active,
    output logic [2*`ECB_NUM_ENC-1:0] touch_active,
    output logic [`ECB_NUM_ENC-1:0][`ECB_CNT_W-1:0] count_now,
    output logic [`ECB_NUM_ENC-1:0][`ECB_CNT_W-1:0] captured_count,
    output logic [`ECB_NUM_ENC-1:0] dir_cw,
    output logic [`ECB_NUM_ENC-1:0] preset_armed_flag,
    output logic [`ECB_NUM_ENC-1:0] capture_armed_flag
);

    ecb_state_s s_r;
    ecb_state_s s_nxt;

    logic [`ECB_NUM_IN-1:0] filt_nxt;
    logic [`ECB_NUM_IN-1:0][`ECB_FCNT_W-1:0] fcnt_nxt;
    logic [`ECB_NUM_IN-1:0] role_mask;
    logic [`ECB_NUM_ENC-1:0][`ECB_CNT_W-1:0] count_nxt;
    logic [`ECB_NUM_ENC-1:0][`ECB_CNT_W-1:0] capt_nxt;
    logic [`ECB_NUM_ENC-1:0] dir_nxt;

    // Per-input debounce: the level is taken once it has held for the selected delay
    genvar gi;
    generate
        for (gi = 0; gi < `ECB_NUM_IN; gi++)
        begin : g_filter
            logic [`ECB_FCNT_W-1:0] limit;
            logic [`ECB_FCNT_W-1:0] cnt_inc;

            always_comb
            begin
                case (ecb_dly_e'(delay_sel[gi]))
                    ECB_DLY_8MS: limit = `ECB_FCNT_W'(FILT_8MS_CYC);
                    ECB_DLY_1MS: limit = `ECB_FCNT_W'(FILT_1MS_CYC);
                    ECB_DLY_100US: limit = `ECB_FCNT_W'(`ECB_DLY_100US_CYC);
                    default: limit = `ECB_FCNT_W'(`ECB_DLY_MIN_CYC);
                endcase
            end

            assign cnt_inc = s_r.fcnt[gi] + `ECB_FCNT_W'(1);

            always_comb
            begin
                filt_nxt[gi] = s_r.filt[gi];
                fcnt_nxt[gi] = '0;
                if (s_r.sync[gi] != s_r.filt[gi])
                begin
                    if (cnt_inc >= limit)
                    begin
                        filt_nxt[gi] = s_r.sync[gi];
                    end
                    else
                    begin
                        fcnt_nxt[gi] = cnt_inc;
                    end
                end
            end
        end
    endgenerate

    // Per-encoder counting, preset, wrap and capture
    genvar ge;
    generate
        for (ge = 0; ge < `ECB_NUM_ENC; ge++)
        begin : g_enc
            localparam int CH_A = `ECB_ENC_A_BASE + `ECB_ENC_STRIDE * ge;
            localparam int CH_B = CH_A + 1;
            localparam int CH_T = `ECB_TOUCH_BASE + 2 * ge;
            logic a_rise;
            logic a_fall;
            logic b_lvl;
            logic step_up;
            logic step_dn;
            logic touch_lvl;
            logic touch_prev;
            logic touch_edge;
            logic counting;
            logic [`ECB_CNT_W-1:0] inc;

            assign a_rise = s_r.filt[CH_A] & ~s_r.filt_d[CH_A];
            assign a_fall = ~s_r.filt[CH_A] & s_r.filt_d[CH_A];
            assign b_lvl = s_r.filt[CH_B];
            // Touch/reset level is the OR of this encoder's enabled touch inputs
            assign touch_lvl = |(s_r.filt[CH_T +: 2] & s_r.touch_on[CH_T +: 2]);
            assign touch_prev = |(s_r.filt_d[CH_T +: 2] & s_r.touch_on[CH_T +: 2]);
            assign touch_edge = touch_lvl & ~touch_prev;
            assign counting = count_enable[ge] & s_r.enc_on[ge];
            assign inc = s_r.count[ge] + `ECB_CNT_W'(1);

            // Edge qualification by mode
            always_comb
            begin
                if (count_mode[ge] == `ECB_MODE_QUAD)
                begin
                    step_up = a_rise & b_lvl;
                    step_dn = a_fall & b_lvl;
                end
                else
                begin
                    step_up = a_rise & ~b_lvl;
                    step_dn = a_rise & b_lvl;
                end
            end

            // Next count: set, then touch preset, then counting
            always_comb
            begin
                count_nxt[ge] = s_r.count[ge];
                dir_nxt[ge] = s_r.dir_cw[ge];
                if (count_set[ge])
                begin
                    count_nxt[ge] = count_preset[ge];
                end
                else if (preset_arm[ge] && touch_edge)
                begin
                    count_nxt[ge] = count_preset[ge];
                end
                else if (counting && step_up)
                begin
                    dir_nxt[ge] = 1'h1;
                    if (wrap_limit_on[ge] && inc == wrap_ceiling[ge])
                    begin
                        count_nxt[ge] = '0;
                    end
                    else
                    begin
                        count_nxt[ge] = inc;
                    end
                end
                else if (counting && step_dn)
                begin
                    dir_nxt[ge] = 1'h0;
                    if (wrap_limit_on[ge] && s_r.count[ge] == '0 && wrap_ceiling[ge] != '0)
                    begin
                        count_nxt[ge] = wrap_ceiling[ge] - `ECB_CNT_W'(1);
                    end
                    else
                    begin
                        count_nxt[ge] = s_r.count[ge] - `ECB_CNT_W'(1);
                    end
                end
            end

            // Capture takes the count as it stood before this edge
            assign capt_nxt[ge] = (capture_arm[ge] && touch_edge) ? s_r.count[ge]
                                                                 : s_r.capt[ge];
        end
    endgenerate

    // Inputs taken over by an encoder or touch/reset role
    always_comb
    begin
        role_mask = '0;
        for (int e = 0; e < `ECB_NUM_ENC; e++)
        begin
            role_mask[`ECB_ENC_A_BASE + `ECB_ENC_STRIDE * e] = s_r.enc_on[e];
            role_mask[`ECB_ENC_A_BASE + `ECB_ENC_STRIDE * e + 1] = s_r.enc_on[e];
        end
        role_mask[`ECB_TOUCH_BASE +: 2*`ECB_NUM_ENC] = s_r.touch_on;
    end

    // Next state of the whole block
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.meta = din_pin;
        s_nxt.sync = s_r.meta;
        s_nxt.filt = filt_nxt;
        s_nxt.fcnt = fcnt_nxt;
        s_nxt.filt_d = s_r.filt;
        s_nxt.enc_on = enc_cfg;
        for (int e = 0; e < `ECB_NUM_ENC; e++)
        begin
            s_nxt.touch_on[2*e +: 2] = touch_cfg[2*e +: 2] & {2{enc_cfg[e]}};
        end
        s_nxt.count = count_nxt;
        s_nxt.capt = capt_nxt;
        s_nxt.dir_cw = dir_nxt;
        s_nxt.pre_flag = preset_arm;
        s_nxt.cap_flag = capture_arm;
    end

    // State register
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign din_filtered = s_r.filt;
    assign plain_input = s_r.filt & ~role_mask;
    assign enc_active = s_r.enc_on;
    assign touch_active = s_r.touch_on;
    assign count_now = s_r.count;
    assign captured_count = s_r.capt;
    assign dir_cw = s_r.dir_cw;
    assign preset_armed_flag = s_r.pre_flag;
    assign capture_armed_flag = s_r.cap_flag;

endmodule : ecb_encoder_count_block

// *** rtl/ecb_pkg.sv ***
/*
 * Types of the A/B encoder counter: filter delay codes and the state record.
 * Assumes ecb_defs.svh is on the include path.
 */
`include "ecb_defs.svh"

package ecb_pkg;

    // Filter delay select codes; code zero is the power-up default
    typedef enum logic [1:0] {
        ECB_DLY_8MS,
        ECB_DLY_1MS,
        ECB_DLY_100US,
        ECB_DLY_NONE
    } ecb_dly_e;

    // Whole state of the counter block
    typedef struct packed {
        logic [`ECB_NUM_IN-1:0] meta;
        logic [`ECB_NUM_IN-1:0] sync;
        logic [`ECB_NUM_IN-1:0] filt;
        logic [`ECB_NUM_IN-1:0] filt_d;
        logic [`ECB_NUM_IN-1:0][`ECB_FCNT_W-1:0] fcnt;
        logic [`ECB_NUM_ENC-1:0] enc_on;
        logic [2*`ECB_NUM_ENC-1:0] touch_on;
        logic [`ECB_NUM_ENC-1:0][`ECB_CNT_W-1:0] count;
        logic [`ECB_NUM_ENC-1:0][`ECB_CNT_W-1:0] capt;
        logic [`ECB_NUM_ENC-1:0] pre_flag;
        logic [`ECB_NUM_ENC-1:0] cap_flag;
        logic [`ECB_NUM_ENC-1:0] dir_cw;
    } ecb_state_s;

endpackage : ecb_pkg

// *** testbench/ecb_counter_monitor.sv ***
/*
 * Port checker of the encoder counter: encoder 0 counting and config gating.
 * Assumes it is bound to the counter top; one clock, reset active high.
 */
`timescale 1ns/1ps

module ecb_counter_monitor (
    input logic clock,
    input logic sys_rst,
    input logic [1:0] count_set,
    input logic [1:0][31:0] count_preset,
    input logic [1:0] count_enable,
    input logic [1:0] count_mode,
    input logic [1:0] wrap_limit_on,
    input logic [1:0][31:0] wrap_ceiling,
    input logic [1:0] preset_arm,
    input logic [1:0] enc_active,
    input logic [3:0] touch_active,
    input logic [1:0][31:0] count_now,
    input logic [1:0] dir_cw,
    input logic [1:0] preset_armed_flag
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic [31:0] prev_r; // Count one edge ago
    logic free_r; // No load source acted at the last edge

    // Remember the last count and whether a load could have changed it
    always_ff @(posedge clock)
    begin
        prev_r <= count_now[0];
        free_r <= !count_set[0] && !preset_arm[0] && !wrap_limit_on[0];
    end

    flag_follow_a: assert property (!$past(sys_rst) |-> preset_armed_flag == $past(preset_arm))
        else $error("armed flag does not follow arm");
    set_load_a: assert property (count_set[0] |=> count_now[0] == $past(count_preset[0]))
        else $error("set did not load preset");
    step_one_a: assert property (free_r && count_now[0] != prev_r |->
        count_now[0] - prev_r == 32'h1 || prev_r - count_now[0] == 32'h1) else $error("bad step");
    hold_off_a: assert property ($past(!count_enable[0] && !count_set[0] && !preset_arm[0])
        |-> count_now[0] == prev_r) else $error("count moved while disabled");
    wrap_zero_a: assert property (wrap_limit_on[0] && !count_set[0] && !preset_arm[0]
        && count_now[0] < wrap_ceiling[0] |=> count_now[0] != $past(wrap_ceiling[0]))
        else $error("count reached the ceiling");
    dir_up_a: assert property (!$past(count_mode[0]) && count_now[0] == prev_r + 32'h1
        && free_r |-> dir_cw[0]) else $error("up step without cw direction");
    dir_down_a: assert property (!$past(count_mode[0]) && count_now[0] == prev_r - 32'h1
        && free_r |-> !dir_cw[0]) else $error("down step with cw direction");
    cfg_order_a: assert property ((touch_active[1:0] == 2'h0 || enc_active[0])
        && (touch_active[3:2] == 2'h0 || enc_active[1])) else $error("touch without encoder");

    // Main scenarios: a step up, a wrap to zero, a touch preset
    cover property (free_r && count_now[0] == prev_r + 32'h1);
    cover property (wrap_limit_on[0] && prev_r == 32'h2 && count_now[0] == 32'h0);
    cover property (preset_arm[0] && count_now[0] != prev_r);
endmodule : ecb_counter_monitor

bind ecb_encoder_count_block ecb_counter_monitor ecb_counter_monitor_inst (.clock, .sys_rst,
    .count_set, .count_preset, .count_enable, .count_mode, .wrap_limit_on, .wrap_ceiling,
    .preset_arm, .enc_active, .touch_active, .count_now, .dir_cw, .preset_armed_flag);

// *** testbench/ecb_encoder_count_block_tb.sv ***
/*
 * Bench of the encoder counter: table of track cycles, then hand tests.
 * Assumes the counter, its package, the track model and the checker.
 */
`timescale 1ns/1ps
`define ECB_CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module ecb_encoder_count_block_tb;
    // Rows: model kind, count mode, count delta, cw flag
    localparam logic [35:0] ROWS [4] = '{{2'h0, 1'h0, 32'h1, 1'h1},
        {2'h1, 1'h0, 32'hFFFFFFFF, 1'h0}, {2'h2, 1'h1, 32'h1, 1'h0},
        {2'h3, 1'h1, 32'hFFFFFFFF, 1'h0}};
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic start = 1'b0;
    logic [1:0] kind = 2'h0;
    logic [11:0] pins_r = 12'h000;
    logic [11:0][1:0] delay_sel = {2'h3, 2'h3, 2'h0, {9{2'h3}}};
    logic [1:0] enc_cfg = 2'h1, count_enable = 2'h1, count_mode = 2'h0, count_set = 2'h0;
    logic [1:0] wrap_limit_on = 2'h0, preset_arm = 2'h0, capture_arm = 2'h0;
    logic [3:0] touch_cfg = 4'h5;
    logic [1:0][31:0] count_preset = '0, wrap_ceiling = '0;
    logic [31:0] exp_cnt = 32'h0;
    int err_total = 0, comparisons = 0;
    logic trk_a, trk_b, busy;
    logic [11:0] din_pin, din_filtered, plain_input;
    logic [1:0] enc_active, dir_cw, preset_armed_flag, capture_armed_flag;
    logic [3:0] touch_active;
    logic [1:0][31:0] count_now, captured_count;

    // Encoder 0 tracks come from the model
    assign din_pin = {pins_r[11:6], trk_b, trk_a, pins_r[3:0]};
    ecb_encoder_count_block #(.FILT_8MS_CYC(8), .FILT_1MS_CYC(4)) ecb_encoder_count_block_inst (
        .clock, .sys_rst, .din_pin, .delay_sel, .enc_cfg, .touch_cfg, .count_enable, .count_mode,
        .count_set, .count_preset, .wrap_limit_on, .wrap_ceiling, .preset_arm, .capture_arm,
        .din_filtered, .plain_input, .enc_active, .touch_active, .count_now, .captured_count,
        .dir_cw, .preset_armed_flag, .capture_armed_flag);
    ecb_encoder_model #(.SH(2)) ecb_encoder_model_inst (.clock, .sys_rst, .start, .kind,
        .trk_a, .trk_b, .busy);
    always #20 clock = ~clock;

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick

    // One track cycle, then time for sync, filter and count
    task automatic spin(input logic [1:0] k);
        int w;
        w = 0;
        kind <= k;
        start <= 1'b1;
        tick(1);
        start <= 1'b0;
        tick(1);
        while (busy && w < 50)
        begin
            tick(1);
            w++;
        end
        tick(6);
    endtask : spin

    // Touch input 0 high for five cycles
    task automatic touch;
        pins_r[0] <= 1'b1;
        tick(5);
        pins_r[0] <= 1'b0;
        tick(5);
    endtask : touch

    task automatic give_verdict;
        $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    // Watchdog far beyond the few hundred cycles the tests need
    initial
    begin
        tick(5000);
        err_total++;
        give_verdict;
    end

    // Main sequence
    initial
    begin
        tick(6);
        sys_rst <= 1'b0;
        tick(1);
        `ECB_CHK({count_now, captured_count}, 128'h0)
        pins_r[9] <= 1'b1;
        pins_r[1] <= 1'b1;
        tick(5);
        `ECB_CHK(din_filtered[9], 1'b0)
        tick(10);
        `ECB_CHK({din_filtered[9], plain_input[1]}, 2'h3)
        `ECB_CHK({enc_active, touch_active}, 6'h11)
        $display("done: reset and config");
        for (int i = 0; i < 4; i++)
        begin
            count_mode[0] <= ROWS[i][33];
            spin(ROWS[i][35:34]);
            exp_cnt = exp_cnt + ROWS[i][32:1];
            `ECB_CHK(count_now[0], exp_cnt)
            if (!ROWS[i][33])
                `ECB_CHK(dir_cw[0], ROWS[i][0])
        end
        $display("done: table");
        count_mode[0] <= 1'b0;
        count_enable[0] <= 1'b0;
        spin(2'h0);
        `ECB_CHK(count_now[0], exp_cnt)
        count_enable[0] <= 1'b1;
        count_preset[0] <= 32'hFFFFFFFF;
        count_set[0] <= 1'b1;
        tick(1);
        count_set[0] <= 1'b0;
        tick(2);
        `ECB_CHK(count_now[0], 32'hFFFFFFFF)
        spin(2'h0);
        `ECB_CHK(count_now[0], 32'h0)
        count_preset[0] <= 32'h1;
        wrap_ceiling[0] <= 32'h3;
        wrap_limit_on[0] <= 1'b1;
        count_set[0] <= 1'b1;
        tick(1);
        count_set[0] <= 1'b0;
        spin(2'h0);
        `ECB_CHK(count_now[0], 32'h2)
        spin(2'h0);
        `ECB_CHK(count_now[0], 32'h0)
        wrap_limit_on[0] <= 1'b0;
        spin(2'h0);
        capture_arm[0] <= 1'b1;
        tick(2);
        `ECB_CHK(capture_armed_flag[0], 1'b1)
        touch;
        `ECB_CHK(captured_count[0], 32'h1)
        capture_arm[0] <= 1'b0;
        count_preset[0] <= 32'h00000A5C;
        preset_arm[0] <= 1'b1;
        tick(2);
        touch;
        `ECB_CHK(count_now[0], 32'h00000A5C)
        preset_arm[0] <= 1'b0;
        $display("done: set, wrap and touch");
        give_verdict;
    end
endmodule : ecb_encoder_count_block_tb

// *** testbench/ecb_encoder_model.sv ***
/*
 * Track source of an incremental encoder: one start pulse plays four phases.
 * Assumes start comes from logic on the same clock; tracks idle low.
 */
`timescale 1ns/1ps

module ecb_encoder_model #(
    parameter int SH = 2
)
(
    input logic clock,
    input logic sys_rst,
    input logic start,
    input logic [1:0] kind,
    output logic trk_a,
    output logic trk_b,
    output logic busy
);
    // Track levels per phase: kind 0 cw, 1 ccw, 2 pulse up, 3 pulse down
    localparam logic [3:0] A_TAB [4] = '{4'h6, 4'h3, 4'h6, 4'h6};
    localparam logic [3:0] B_TAB [4] = '{4'h3, 4'h6, 4'h0, 4'hF};
    logic [SH+1:0] cnt_r; // Phase in the top two bits; larger SH plays slower

    // Run once round the four phases, then stand still
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            cnt_r <= '0;
        else if (busy || start)
            cnt_r <= cnt_r + 1'b1;
    end

    // Tracks return low outside a cycle
    assign busy = cnt_r != '0;
    assign trk_a = busy && A_TAB[kind][cnt_r[SH+1:SH]];
    assign trk_b = busy && B_TAB[kind][cnt_r[SH+1:SH]];
endmodule : ecb_encoder_model
